// ==== inc/flash_host_defs.svh ====
// Constants for the flash command host: codes, widths, status bits, timing
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

`define ADDR_W              21
`define DATA_W              16

`define CODE_READ_ARRAY     8'hff
`define CODE_READ_STATUS    8'h70
`define CODE_CLEAR_STATUS   8'h50
`define CODE_QUERY          8'h98
`define CODE_PROGRAM        8'h40
`define CODE_ALT_PROGRAM    8'h10
`define CODE_PROT_PROGRAM   8'hc0
`define CODE_ERASE_SETUP    8'h20
`define CODE_CONFIRM        8'hd0
`define CODE_LOCK_SETUP     8'h60
`define CODE_LOCK           8'h01
`define CODE_LOCKDOWN       8'h2f
`define CODE_SUSPEND        8'hb0

`define STAT_READY_BIT        7
`define STAT_ERASE_PAUSED_BIT 6
`define STAT_ERASE_FAIL_BIT   5
`define STAT_PROG_FAIL_BIT    4
`define STAT_SUPPLY_LOW_BIT   3
`define STAT_PROG_PAUSED_BIT  2
`define STAT_LOCKED_BIT       1
`define STAT_RESERVED_MASK    8'hfe
`define STAT_RESET            8'h80

`define CLK_MHZ             50
`define WE_PULSE_NS         60
`define RD_ACCESS_NS        100
`define WE_CYC              ((`WE_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define ACC_CYC             ((`RD_ACCESS_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== inc/flash_host_pkg.sv ====
// Types shared by the flash command host and its bus cycle engine
package flash_host_pkg;
`include "flash_host_defs.svh"

	typedef enum logic [3:0] {
		OP_READ_ARRAY   = 4'h0,
		OP_READ_STATUS  = 4'h1,
		OP_CFI_READ     = 4'h2,
		OP_PROGRAM      = 4'h3,
		OP_ALT_PROGRAM  = 4'h4,
		OP_PROT_PROGRAM = 4'h5,
		OP_ERASE        = 4'h6,
		OP_LOCK         = 4'h7,
		OP_UNLOCK       = 4'h8,
		OP_LOCKDOWN     = 4'h9,
		OP_CLEAR_STATUS = 4'ha,
		OP_SUSPEND      = 4'hb,
		OP_RESUME       = 4'hc
	} op_t;

	typedef enum logic [1:0] {
		M_ARRAY = 2'b00,
		M_QUERY = 2'b01,
		M_OTHER = 2'b10
	} mode_t;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_FIRST  = 3'b001,
		S_SECOND = 3'b010,
		S_POLL   = 3'b011,
		S_READ   = 3'b100
	} host_state_t;

	typedef enum logic [1:0] {
		B_IDLE    = 2'b00,
		B_SETUP   = 2'b01,
		B_STROBE  = 2'b10,
		B_RECOVER = 2'b11
	} bus_phase_t;

	typedef struct packed {
		op_t                 op;
		logic [`ADDR_W-1:0]  addr;
		logic [`DATA_W-1:0]  data;
	} cmd_t;

	typedef struct packed {
		logic                ce_n;
		logic                oe_n;
		logic                we_n;
		logic [`ADDR_W-1:0]  addr;
		logic [`DATA_W-1:0]  dq;
		logic                dq_oe;
	} flash_pins_t;

	typedef struct packed {
		logic                go;
		logic                wr;
		logic [`ADDR_W-1:0]  addr;
		logic [`DATA_W-1:0]  data;
	} bus_req_t;

	typedef struct packed {
		logic                valid;
		logic [7:0]          first;
		logic [7:0]          second;
		logic                two;
		logic                data2;
		logic                polls;
		logic                reads;
	} plan_t;

	typedef struct packed {
		host_state_t         st;
		mode_t               mode;
		cmd_t                cmd;
		logic [7:0]          status;
		logic [`DATA_W-1:0]  rdata;
		logic                done;
		logic                cmd_err;
		logic                ready;
		bus_req_t            req;
	} host_regs_t;

	typedef struct packed {
		bus_phase_t          ph;
		logic [3:0]          cnt;
		logic                wr;
		flash_pins_t         pins;
		logic [`DATA_W-1:0]  rdata;
		logic                done;
	} bus_regs_t;

endpackage

// ==== rtl/flash_bus_cycle.sv ====
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_bus_cycle (
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	input  wire logic                        en_in,
	input  wire flash_host_pkg::bus_req_t    req_in,
	input  wire logic [`DATA_W-1:0]          dq_in,
	output flash_host_pkg::flash_pins_t      pins_out,
	output logic [`DATA_W-1:0]               rdata_out,
	output logic                             done_out
);
	import flash_host_pkg::*;

	localparam bus_regs_t BUS_RESET = '{ph: B_IDLE, cnt: 4'h0, wr: 1'b0,
		pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0},
		rdata: '0, done: 1'b0};
	localparam logic [3:0] WE_LAST  = 4'(`WE_CYC - 1);
	localparam logic [3:0] ACC_LAST = 4'(`ACC_CYC - 1);

	bus_regs_t q;
	bus_regs_t next_q;

	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		unique case (q.ph)
			B_IDLE: begin
				if (req_in.go) begin
					next_q.wr = req_in.wr;
					next_q.pins.addr = req_in.addr;
					next_q.pins.dq = req_in.data;
					next_q.pins.dq_oe = req_in.wr;
					next_q.pins.ce_n = 1'b0;
					next_q.ph = B_SETUP;
				end
			end
			B_SETUP: begin
				next_q.pins.we_n = ~q.wr;
				next_q.pins.oe_n = q.wr;
				next_q.cnt = q.wr ? WE_LAST : ACC_LAST;
				next_q.ph = B_STROBE;
			end
			B_STROBE: begin
				if (q.cnt == 4'h0) begin
					if (!q.wr)
						next_q.rdata = dq_in;
					// Data still driven one cycle past the rising write strobe
					next_q.pins.we_n = 1'b1;
					next_q.pins.oe_n = 1'b1;
					next_q.ph = B_RECOVER;
				end else begin
					next_q.cnt = q.cnt - 4'h1;
				end
			end
			B_RECOVER: begin
				// Chip select high between cycles so status reads refresh
				next_q.pins.ce_n = 1'b1;
				next_q.pins.dq_oe = 1'b0;
				next_q.done = 1'b1;
				next_q.ph = B_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			q <= BUS_RESET;
		else if (en_in)
			q <= next_q;
	end

	assign pins_out = q.pins;
	assign rdata_out = q.rdata;
	assign done_out = q.done;

	default clocking cb @(posedge clk_in iff en_in); endclocking
	default disable iff (rst_in);

	chk_we_pulse_width: assert property ($fell(q.pins.we_n) |-> !q.pins.we_n [*3] ##1 q.pins.we_n)
		else $error("write strobe width wrong");
	chk_strobe_excl: assert property (!(!q.pins.we_n && !q.pins.oe_n))
		else $error("read and write strobes low together");
	chk_ce_toggle: assert property (q.done |-> q.pins.ce_n && !q.pins.dq_oe)
		else $error("chip select not released between cycles");
endmodule // flash_bus_cycle

// ==== rtl/flash_cmd_host.sv ====
// Host controller issuing command sequences to a parallel boot-block flash
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_cmd_host (
	input  wire logic                        CORE_CLK_IN,
	input  wire logic                        RST_IN,
	input  wire logic                        CLK_EN_IN,
	input  wire logic                        CMD_VALID_IN,
	input  wire flash_host_pkg::cmd_t        CMD_IN,
	output logic                             CMD_READY_OUT,
	output logic                             DONE_OUT,
	output logic [7:0]                       STATUS_OUT,
	output logic                             CMD_ERR_OUT,
	output logic [`DATA_W-1:0]               RDATA_OUT,
	input  wire logic [`DATA_W-1:0]          FLASH_DQ_IN,
	output flash_host_pkg::flash_pins_t      FLASH_PINS_OUT
);
	import flash_host_pkg::*;

	localparam host_regs_t HOST_RESET = '{st: S_IDLE, mode: M_ARRAY, cmd: '0,
		status: `STAT_RESET, rdata: '0, done: 1'b0, cmd_err: 1'b0, ready: 1'b1, req: '0};

	host_regs_t               q;
	host_regs_t               next_q;
	plan_t                    plan_new;
	plan_t                    plan_cur;
	logic                     bus_done;
	logic [`DATA_W-1:0]       bus_rdata;
	logic                     skip_first;

	// Only assigned codes are ever produced here, so reserved ones never reach the pins
	function automatic plan_t plan_of(input op_t op);
		plan_t p;
		p = '0;
		p.valid = 1'b1;
		unique case (op)
			OP_READ_ARRAY: begin
				p.first = `CODE_READ_ARRAY;
				p.reads = 1'b1;
			end
			OP_READ_STATUS: begin
				p.first = `CODE_READ_STATUS;
				p.reads = 1'b1;
			end
			OP_CFI_READ: begin
				p.first = `CODE_QUERY;
				p.reads = 1'b1;
			end
			OP_PROGRAM: begin
				p.first = `CODE_PROGRAM;
				p.two = 1'b1;
				p.data2 = 1'b1;
				p.polls = 1'b1;
			end
			OP_ALT_PROGRAM: begin
				p.first = `CODE_ALT_PROGRAM;
				p.two = 1'b1;
				p.data2 = 1'b1;
				p.polls = 1'b1;
			end
			OP_PROT_PROGRAM: begin
				p.first = `CODE_PROT_PROGRAM;
				p.two = 1'b1;
				p.data2 = 1'b1;
				p.polls = 1'b1;
			end
			OP_ERASE: begin
				p.first = `CODE_ERASE_SETUP;
				p.second = `CODE_CONFIRM;
				p.two = 1'b1;
				p.polls = 1'b1;
			end
			OP_LOCK: begin
				p.first = `CODE_LOCK_SETUP;
				p.second = `CODE_LOCK;
				p.two = 1'b1;
			end
			OP_UNLOCK: begin
				p.first = `CODE_LOCK_SETUP;
				p.second = `CODE_CONFIRM;
				p.two = 1'b1;
			end
			OP_LOCKDOWN: begin
				p.first = `CODE_LOCK_SETUP;
				p.second = `CODE_LOCKDOWN;
				p.two = 1'b1;
			end
			OP_CLEAR_STATUS: p.first = `CODE_CLEAR_STATUS;
			OP_SUSPEND: begin
				p.first = `CODE_SUSPEND;
				p.polls = 1'b1;
			end
			OP_RESUME: begin
				p.first = `CODE_CONFIRM;
				p.polls = 1'b1;
			end
			default: p = '0;
		endcase
		return p;
	endfunction

	function automatic bus_req_t launch(input logic wr, input logic [`ADDR_W-1:0] addr,
			input logic [`DATA_W-1:0] data);
		bus_req_t r;
		r.go = 1'b1;
		r.wr = wr;
		r.addr = addr;
		r.data = data;
		return r;
	endfunction

	function automatic mode_t mode_after(input logic [7:0] code);
		if (code == `CODE_READ_ARRAY)
			return M_ARRAY;
		else if (code == `CODE_QUERY)
			return M_QUERY;
		return M_OTHER;
	endfunction

	assign plan_new = plan_of(CMD_IN.op);
	assign plan_cur = plan_of(q.cmd.op);
	// Redundant read-array and query writes are skipped while the device already sits in that mode
	assign skip_first = (CMD_IN.op == OP_READ_ARRAY && q.mode == M_ARRAY) ||
		(CMD_IN.op == OP_CFI_READ && q.mode == M_QUERY);

	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		next_q.req.go = 1'b0;
		unique case (q.st)
			S_IDLE: begin
				if (CMD_VALID_IN && q.ready) begin
					next_q.cmd = CMD_IN;
					if (!plan_new.valid) begin
						next_q.done = 1'b1;
					end else if (skip_first) begin
						next_q.ready = 1'b0;
						next_q.req = launch(1'b0, CMD_IN.addr, '0);
						next_q.st = S_READ;
					end else begin
						next_q.ready = 1'b0;
						next_q.req = launch(1'b1, CMD_IN.addr, {8'h00, plan_new.first});
						next_q.st = S_FIRST;
					end
				end
			end
			S_FIRST: begin
				if (bus_done) begin
					next_q.mode = mode_after(plan_cur.first);
					if (plan_cur.two) begin
						next_q.req = launch(1'b1, q.cmd.addr,
							plan_cur.data2 ? q.cmd.data : {8'h00, plan_cur.second});
						next_q.st = S_SECOND;
					end else if (plan_cur.reads) begin
						next_q.req = launch(1'b0, q.cmd.addr, '0);
						next_q.st = S_READ;
					end else if (plan_cur.polls) begin
						next_q.req = launch(1'b0, q.cmd.addr, '0);
						next_q.st = S_POLL;
					end else begin
						next_q.done = 1'b1;
						next_q.ready = 1'b1;
						next_q.st = S_IDLE;
					end
				end
			end
			S_SECOND: begin
				if (bus_done) begin
					if (plan_cur.polls) begin
						// Started operation leaves the device answering with status
						next_q.req = launch(1'b0, q.cmd.addr, '0);
						next_q.st = S_POLL;
					end else begin
						next_q.done = 1'b1;
						next_q.ready = 1'b1;
						next_q.st = S_IDLE;
					end
				end
			end
			S_POLL: begin
				if (bus_done) begin
					if (bus_rdata[`STAT_READY_BIT]) begin
						next_q.status = bus_rdata[7:0] & `STAT_RESERVED_MASK;
						next_q.cmd_err = bus_rdata[`STAT_PROG_FAIL_BIT] & bus_rdata[`STAT_ERASE_FAIL_BIT];
						next_q.done = 1'b1;
						next_q.ready = 1'b1;
						next_q.st = S_IDLE;
					end else begin
						// No timeout: a stuck sequencer holds the host busy until reset
						next_q.req = launch(1'b0, q.cmd.addr, '0);
					end
				end
			end
			S_READ: begin
				if (bus_done) begin
					next_q.rdata = bus_rdata;
					if (q.cmd.op == OP_READ_STATUS) begin
						next_q.status = bus_rdata[7:0] & `STAT_RESERVED_MASK;
						next_q.cmd_err = bus_rdata[`STAT_PROG_FAIL_BIT] & bus_rdata[`STAT_ERASE_FAIL_BIT];
					end
					next_q.done = 1'b1;
					next_q.ready = 1'b1;
					next_q.st = S_IDLE;
				end
			end
			default: begin
				next_q = HOST_RESET;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			q <= HOST_RESET;
		else if (CLK_EN_IN)
			q <= next_q;
	end

	flash_bus_cycle u_bus (
		.clk_in    (CORE_CLK_IN),
		.rst_in    (RST_IN),
		.en_in     (CLK_EN_IN),
		.req_in    (q.req),
		.dq_in     (FLASH_DQ_IN),
		.pins_out  (FLASH_PINS_OUT),
		.rdata_out (bus_rdata),
		.done_out  (bus_done)
	);

	assign CMD_READY_OUT = q.ready;
	assign DONE_OUT = q.done;
	assign STATUS_OUT = q.status;
	assign CMD_ERR_OUT = q.cmd_err;
	assign RDATA_OUT = q.rdata;

	default clocking cb @(posedge CORE_CLK_IN iff CLK_EN_IN); endclocking
	default disable iff (RST_IN);

	chk_legal_code: assert property (q.req.go && q.st == S_FIRST |->
		q.req.data[7:0] != 8'h00 && q.req.wr)
		else $error("reserved command code written");
	chk_prog_second: assert property (q.st == S_FIRST && bus_done &&
		q.cmd.op inside {OP_PROGRAM, OP_ALT_PROGRAM} |=> q.st == S_SECOND && q.req.go && q.req.data == q.cmd.data)
		else $error("program data cycle missing");
	chk_prot_code: assert property (q.req.go && q.st == S_FIRST && q.cmd.op == OP_PROT_PROGRAM |->
		q.req.data[7:0] == `CODE_PROT_PROGRAM ##1 !q.req.go [*2])
		else $error("protection program code wrong");
	chk_alt_code: assert property (q.req.go && q.st == S_FIRST && q.cmd.op == OP_ALT_PROGRAM |->
		q.req.data[7:0] == `CODE_ALT_PROGRAM)
		else $error("alternate program code wrong");
	chk_lock_code: assert property (q.req.go && q.st == S_SECOND && q.cmd.op == OP_LOCK |->
		q.req.data[7:0] == `CODE_LOCK && $past(q.st, 2) != S_IDLE)
		else $error("lock confirm code wrong");
	chk_lockdown_code: assert property (q.req.go && q.st == S_SECOND && q.cmd.op == OP_LOCKDOWN |->
		q.req.data[7:0] == `CODE_LOCKDOWN)
		else $error("lock-down confirm code wrong");
	chk_query_mode: assert property (q.req.go && q.st == S_READ && q.cmd.op == OP_CFI_READ |->
		q.mode == M_QUERY)
		else $error("query read outside query mode");
	chk_array_mode: assert property (q.req.go && q.st == S_READ && q.cmd.op == OP_READ_ARRAY |->
		q.mode == M_ARRAY)
		else $error("array read without read-array code");
	chk_ready_poll: assert property (q.st == S_POLL && bus_done && !bus_rdata[`STAT_READY_BIT] |=>
		q.st == S_POLL && q.req.go && !q.done)
		else $error("result taken while sequencer busy");
	chk_mask_bit0: assert property ($rose(q.done) |-> !q.status[0] && q.ready)
		else $error("reserved status bit not masked");

	cov_program: cover property (q.st == S_POLL && q.cmd.op == OP_PROGRAM ##1 q.done);
	cov_erase: cover property (q.st == S_POLL && q.cmd.op == OP_ERASE ##1 q.done);
	cov_lock: cover property (q.st == S_SECOND && q.cmd.op == OP_LOCK ##[1:20] q.done);
	cov_query: cover property (q.st == S_READ && q.cmd.op == OP_CFI_READ ##[1:20] q.done);
endmodule // flash_cmd_host

// ==== bench/flash_dev_model.sv ====
// Behavioural flash device answering the host's bus cycles
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [15:0] QUERY_WORD = 16'h0051
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire flash_pins_t pins_in,
	input  wire logic        supply_low_in,
	input  wire logic        erase_bad_in,
	output logic             bad_code_out,
	output logic [15:0]      dq_out
);
	logic [15:0] mem [16];
	logic [31:0] lk;
	logic [31:0] ld;
	logic [6:1]  stw;
	logic [1:0]  mode;
	logic [1:0]  busy;
	logic [7:0]  pend;
	logic        er;
	logic        we_q;
	logic        oe_q;
	logic        rdy;
	logic [15:0] last;
	logic [15:0] rd;
	logic [4:0]  blk;
	logic [7:0]  c;
	assign blk = pins_in.addr[20:16];
	assign c = pins_in.dq[7:0];
	assign rdy = (busy == 2'd0) || stw[6] || stw[2];
	// Reserved bit reads 1 so an unmasking host shows up
	assign rd = (mode == 2'd1) ? {8'h00, rdy, stw[6:1], 1'b1} : (mode == 2'd2) ? QUERY_WORD : mem[pins_in.addr[3:0]];
	// Released bus shows the inverse of the last value
	assign dq_out = (!pins_in.ce_n && !pins_in.oe_n) ? rd : ~last;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lk <= '1;
			ld <= '0;
			stw <= '0;
			mode <= 2'd0;
			busy <= 2'd0;
			pend <= 8'h00;
			er <= 1'b0;
			bad_code_out <= 1'b0;
			we_q <= 1'b1;
			oe_q <= 1'b1;
			last <= 16'h0000;
			for (int i = 0; i < 16; i++) mem[i] <= 16'hffff;
		end else begin
			we_q <= pins_in.we_n;
			oe_q <= pins_in.oe_n;
			if (!pins_in.ce_n && !pins_in.oe_n) last <= rd;
			if (!oe_q && pins_in.oe_n && mode == 2'd1 && !rdy) busy <= busy - 2'd1;
			if (!we_q && pins_in.we_n && !pins_in.ce_n) begin
				pend <= 8'h00;
				case (pend)
				8'h40, 8'h10, 8'hc0, 8'h20: begin
					mode <= 2'd1;
					busy <= 2'd2;
					er <= (pend == 8'h20);
					if (pend == 8'h20 && c != 8'hd0) stw[5:4] <= 2'b11;
					else if (supply_low_in) stw[3] <= 1'b1;
					else if (pend != 8'hc0 && lk[blk]) stw[1] <= 1'b1;
					else if (pend == 8'h20 && erase_bad_in) stw[5] <= 1'b1;
					else if (pend == 8'h20) for (int i = 0; i < 16; i++) mem[i] <= 16'hffff;
					else if (pend == 8'hc0) ;
					else if ((mem[pins_in.addr[3:0]] & pins_in.dq) != pins_in.dq) stw[4] <= 1'b1;
					else mem[pins_in.addr[3:0]] <= pins_in.dq;
				end
				8'h60: case (c)
					8'h01: lk[blk] <= 1'b1;
					8'h2f: begin
						lk[blk] <= 1'b1;
						ld[blk] <= 1'b1;
					end
					8'hd0: if (!ld[blk]) lk[blk] <= 1'b0;
					default: begin
						stw[5:4] <= 2'b11;
						mode <= 2'd1;
					end
				endcase
				default: case (c)
					8'hff: mode <= 2'd0;
					8'h70: mode <= 2'd1;
					8'h50: {stw[5:3], stw[1]} <= 4'h0;
					8'h98: mode <= 2'd2;
					8'h40, 8'h10, 8'hc0, 8'h20, 8'h60: pend <= c;
					8'hb0: if (!rdy) begin
						if (er) stw[6] <= 1'b1;
						else stw[2] <= 1'b1;
						mode <= 2'd1;
					end
					8'hd0: {stw[6], stw[2]} <= 2'b00;
					default: bad_code_out <= 1'b1;
				endcase
				endcase
			end
		end
	end
endmodule // flash_dev_model

// ==== bench/flash_cmd_host_tb.sv ====
// Self-checking bench: host against the device model
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_cmd_host_tb;
	import flash_host_pkg::*;
	logic        clk = 0;
	logic        rst = 1;
	logic        valid = 0;
	cmd_t        cmd = '0;
	logic        ready;
	logic        done;
	logic [7:0]  status;
	logic        err;
	logic [15:0] rdata;
	logic [15:0] dq;
	logic [15:0] dev_dq;
	flash_pins_t pins;
	logic        low = 0;
	logic        bad = 0;
	logic        bad_code;
	int          fails = 0;
	int          cmp_count = 0;
	int          ce_seen = 0;
	int          n;
	int          ce_base;
	always #10 clk = ~clk;
	always @(negedge clk) if (pins.ce_n === 1'b0) ce_seen++;
	assign dq = pins.dq_oe ? pins.dq : dev_dq;
	flash_cmd_host i_flash_cmd_host (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(1'b1), .CMD_VALID_IN(valid),
		.CMD_IN(cmd), .CMD_READY_OUT(ready), .DONE_OUT(done), .STATUS_OUT(status), .CMD_ERR_OUT(err),
		.RDATA_OUT(rdata), .FLASH_DQ_IN(dq), .FLASH_PINS_OUT(pins));
	flash_dev_model i_flash_dev_model (.clk_in(clk), .rst_in(rst), .pins_in(pins), .supply_low_in(low),
		.erase_bad_in(bad), .bad_code_out(bad_code), .dq_out(dev_dq));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Request waits for ready, done is bounded so a stuck poll cannot hang
	// Outputs are looked at on the falling edge, where they have settled
	task automatic run(input op_t op, input logic [20:0] a, input logic [15:0] d);
		n = 0;
		@(negedge clk);
		while (ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		valid <= 1'b1;
		cmd <= '{op, a, d};
		@(posedge clk);
		valid <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			fails++;
			conclude();
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("ready", ready, 1);
		check("status", status, 8'h80);
		$display("test reset done");
		run(OP_PROGRAM, 21'h010000, 16'h1234);
		check("status", status, 8'h82);
		check("err", err, 0);
		run(OP_CLEAR_STATUS, 21'h0, 16'h0);
		run(OP_READ_STATUS, 21'h0, 16'h0);
		check("status", status, 8'h80);
		run(OP_UNLOCK, 21'h010000, 16'h0);
		run(OP_PROGRAM, 21'h010000, 16'h1234);
		check("status", status, 8'h80);
		check("bit0", status[0], 0);
		run(OP_READ_ARRAY, 21'h010000, 16'h0);
		check("array", rdata, 16'h1234);
		run(OP_READ_ARRAY, 21'h010001, 16'h0);
		check("array", rdata, 16'hffff);
		run(OP_ALT_PROGRAM, 21'h010001, 16'h5a5a);
		run(OP_READ_ARRAY, 21'h010001, 16'h0);
		check("array", rdata, 16'h5a5a);
		run(OP_ALT_PROGRAM, 21'h010001, 16'hffff);
		check("status", status, 8'h90);
		$display("test program done");
		run(OP_CLEAR_STATUS, 21'h0, 16'h0);
		low <= 1'b1;
		run(OP_PROGRAM, 21'h010002, 16'h0f0f);
		check("status", status, 8'h88);
		low <= 1'b0;
		run(OP_CLEAR_STATUS, 21'h0, 16'h0);
		run(OP_CFI_READ, 21'h000010, 16'h0);
		check("query", rdata, 16'h0051);
		run(OP_PROT_PROGRAM, 21'h000081, 16'h00aa);
		check("status", status, 8'h80);
		run(OP_READ_ARRAY, 21'h010001, 16'h0);
		check("array", rdata, 16'h5a5a);
		$display("test modes done");
		bad <= 1'b1;
		run(OP_ERASE, 21'h010000, 16'h0);
		check("status", status, 8'ha0);
		run(OP_ALT_PROGRAM, 21'h010001, 16'hffff);
		check("status", status, 8'hb0);
		check("err", err, 1);
		bad <= 1'b0;
		run(OP_CLEAR_STATUS, 21'h0, 16'h0);
		run(OP_ERASE, 21'h010000, 16'h0);
		run(OP_READ_ARRAY, 21'h010001, 16'h0);
		check("erased", rdata, 16'hffff);
		$display("test erase done");
		run(OP_LOCK, 21'h010000, 16'h0);
		run(OP_PROGRAM, 21'h010003, 16'h0001);
		check("status", status, 8'h82);
		run(OP_CLEAR_STATUS, 21'h0, 16'h0);
		run(OP_LOCKDOWN, 21'h020000, 16'h0);
		run(OP_UNLOCK, 21'h020000, 16'h0);
		run(OP_PROGRAM, 21'h020000, 16'h0001);
		check("status", status, 8'h82);
		$display("test locking done");
		ce_base = ce_seen;
		run(op_t'(4'hd), 21'h0, 16'h0);
		check("ce", ce_seen - ce_base, 0);
		check("status", status, 8'h82);
		check("code", bad_code, 0);
		$display("test invalid done");
		run(OP_CLEAR_STATUS, 21'h0, 16'h0);
		run(OP_READ_STATUS, 21'h0, 16'h0);
		run(OP_SUSPEND, 21'h0, 16'h0);
		check("status", status, 8'h80);
		run(OP_RESUME, 21'h0, 16'h0);
		check("status", status, 8'h80);
		check("err", err, 0);
		$display("test suspend done");
		conclude();
	end
endmodule // flash_cmd_host_tb
